// ### shared/io_clk_pkg.sv
/*
 * Constants and types shared by the I/O decode and baud clock design.
 * Assumes a single 20 MHz system clock that drives every flip-flop.
 */
package io_clk_pkg;

    // clock rates, in hertz
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int BASE_CLK_HZ = 2_000_000;
    localparam int CPU_FAST_HZ = 4_000_000;
    localparam int CPU_SLOW_HZ = 2_000_000;

    // divide ratios derived from the rates
    localparam int BASE_DIV = SYS_CLK_HZ / BASE_CLK_HZ;
    localparam int CPU_FAST_DIV = SYS_CLK_HZ / CPU_FAST_HZ;
    localparam int CPU_SLOW_DIV = SYS_CLK_HZ / CPU_SLOW_HZ;

    // baud chain: divide by 13 for 9600, by 11 from 1200 for 110
    localparam int BAUD_TOP_DIV = 13;
    localparam int BAUD_110_DIV = 11;
    localparam int HALVING_STAGES = 6;
    localparam int STAGE_1200 = 2;

    // low address nibbles inside the configured i/o block
    localparam logic [3:0] PORT_A_LO = 4'h8;
    localparam logic [3:0] PORT_B_LO = 4'h9;
    localparam logic [3:0] PORT_C_LO = 4'hA;
    localparam logic [3:0] CSR_LO = 4'hB;
    localparam logic [3:0] SERIAL_DATA_LO = 4'h4;
    localparam logic [3:0] SERIAL_CTRL_LO = 4'h5;

    // baud switch codes
    typedef enum logic [2:0] {
        BAUD_9600 = 3'h0,
        BAUD_4800 = 3'h1,
        BAUD_2400 = 3'h2,
        BAUD_1200 = 3'h3,
        BAUD_600 = 3'h4,
        BAUD_300 = 3'h5,
        BAUD_150 = 3'h6,
        BAUD_110 = 3'h7
    } baud_sel_e;

    // clock pair that feeds one serial port
    typedef struct packed {
        logic tx;
        logic rx;
    } serial_clk_s;

    // selects to the parallel and serial chips
    typedef struct packed {
        logic parallel;
        logic port_a;
        logic port_b;
        logic port_c;
        logic csr;
        logic serial;
        logic serial_ctrl;
    } io_sel_s;

endpackage : io_clk_pkg

// ### hw/mod_divider.sv
/*
 * Free-running modulo counter that advances on an enable pulse.
 * Assumes en comes from logic on the same clock.
 */
`timescale 1ns/1ps
module mod_divider #(
    parameter int MODULUS = 13
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // advance enable and results
    input wire logic en,
    output logic [$clog2(MODULUS)-1:0] count,
    output logic tick
);

    localparam int CW = $clog2(MODULUS);
    localparam logic [CW-1:0] LAST = CW'(MODULUS - 1);

    // a modulus below two leaves no count to wrap
    if (MODULUS < 2) $error("mod_divider needs a modulus of two or more");

    // the counter never stops; reset only gives it a known phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else if (en) begin
            count <= (count == LAST) ? '0 : count + 1'b1;
        end
    end

    // gated terminal count, one cycle wide
    assign tick = en && (count == LAST);

endmodule : mod_divider

// ### hw/io_decode_and_baud_clocks.sv
/*
 * I/O address decode, address mirroring, processor clock enable and
 * switch-selected baud clocks for the serial ports.
 * Assumes address and strobe come from logic on clk; straps and switches
 * are static pins and are synchronised before use.
 */
// What this block does
// R1: ports A, B, C at x8, x9, xA
// R2: control/status register selected at xB
// R3: section selects need address and request strobe
// R4: processor clock 4 or 2 MHz by strap
// R5: divide 2 MHz base by 13 first
// R6: top baud clock near 153.6 kHz
// R7: lower rates by successive halving stages
// R8: 110 baud clock is 1200 clock over 11
// R9: switch picks clock for transmit and receive
// R10: mirror low address byte onto high byte on i/o cycles
// R11: dividers run freely, outputs always toggle
`timescale 1ns/1ps
module io_decode_and_baud_clocks #(
    parameter int NUM_PORTS = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // processor side
    input wire logic [15:0] address,
    input wire logic io_cycle,
    input wire logic memory_request_strobe_n,
    output logic [15:0] address_out,
    output io_clk_pkg::io_sel_s io_sel,
    // static straps and switches
    input wire logic [3:0] base_nibble,
    input wire logic mirror_enable,
    input wire logic cpu_fast,
    input wire logic [NUM_PORTS-1:0][2:0] baud_switch,
    // clocks out
    output logic cpu_clk_tick,
    output logic two_mhz_base_clock,
    output io_clk_pkg::serial_clk_s [NUM_PORTS-1:0] port_clk
);
    import io_clk_pkg::*;
    default clocking dclk @(posedge clk); endclocking
    default disable iff (!nrst);

    if (NUM_PORTS < 1) $error("at least one serial port is needed");

    ////////////////////////////////////////////////////////////////////////
    // strap synchronisers: first stage feeds only the second
    logic [3:0] nib_meta, nib_q;
    logic mir_meta, mir_q, fast_meta, fast_q;
    logic [NUM_PORTS-1:0][2:0] sw_meta, sw_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nib_meta <= 4'h0;
            nib_q <= 4'h0;
            mir_meta <= 1'b0;
            mir_q <= 1'b0;
            fast_meta <= 1'b0;
            fast_q <= 1'b0;
            sw_meta <= '0;
            sw_q <= '0;
        end else begin
            nib_meta <= base_nibble;
            nib_q <= nib_meta;
            mir_meta <= mirror_enable;
            mir_q <= mir_meta;
            fast_meta <= cpu_fast;
            fast_q <= fast_meta;
            sw_meta <= baud_switch;
            sw_q <= sw_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode
    logic io_req;
    assign io_req = io_cycle && !memory_request_strobe_n; // see R3

    function automatic logic hit(input logic [15:0] a, input logic [3:0] lo,
                                 input logic [3:0] hi);
        hit = (a[7:4] == hi) && (a[3:0] == lo);
    endfunction : hit

    // registered so the chip selects are glitch free
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            io_sel <= '0;
        end else begin
            io_sel.port_a <= io_req
                && hit(address, PORT_A_LO, nib_q); // see R1
            io_sel.port_b <= io_req
                && hit(address, PORT_B_LO, nib_q); // see R1
            io_sel.port_c <= io_req
                && hit(address, PORT_C_LO, nib_q); // see R1
            io_sel.csr <= io_req && hit(address, CSR_LO, nib_q); // see R2
            io_sel.parallel <= io_req && (address[7:4] == nib_q)
                && (address[3:2] == PORT_A_LO[3:2]); // see R3
            io_sel.serial <= io_req && (hit(address, SERIAL_DATA_LO, nib_q)
                || hit(address, SERIAL_CTRL_LO, nib_q)); // see R3
            io_sel.serial_ctrl <= io_req
                && hit(address, SERIAL_CTRL_LO, nib_q);
        end
    end

    // upper byte copies the lower one on mirrored i/o cycles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            address_out <= 16'h0000;
        end else if (io_cycle && mir_q) begin
            address_out <= {address[7:0], address[7:0]}; // see R10
        end else begin
            address_out <= address;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // base and processor clocks; no reset beyond phase alignment
    logic base_tick, fast_tick;
    logic [$clog2(BASE_DIV)-1:0] base_cnt;

    mod_divider #(.MODULUS(BASE_DIV)) u_base (
        .clk(clk),
        .nrst(nrst),
        .en(1'b1),
        .count(base_cnt),
        .tick(base_tick)
    ); // see R11

    mod_divider #(.MODULUS(CPU_FAST_DIV)) u_cpu (
        .clk(clk),
        .nrst(nrst),
        .en(1'b1),
        .count(),
        .tick(fast_tick)
    );

    // slow rate equals the base rate, so reuse its enable
    assign cpu_clk_tick = fast_q ? fast_tick : base_tick; // see R4

    // square base clock: high for the first half of each period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            two_mhz_base_clock <= 1'b0;
        end else begin
            two_mhz_base_clock <= (base_cnt < BASE_DIV / 2);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // baud chain
    logic top_tick;
    logic [HALVING_STAGES-1:0] halves;
    logic r1200_d, rise_1200, tick_110;
    logic [$clog2(BAUD_110_DIV)-1:0] cnt_110;

    mod_divider #(.MODULUS(BAUD_TOP_DIV)) u_top (
        .clk(clk),
        .nrst(nrst),
        .en(base_tick),
        .count(),
        .tick(top_tick)
    ); // see R5

    // binary counter: bit k runs at the top rate over 2**(k+1)
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            halves <= '0;
        end else if (top_tick) begin
            halves <= halves + 1'b1; // see R7
        end
    end

    // rising edge of the 1200 clock advances the eleven stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r1200_d <= 1'b0;
        end else begin
            r1200_d <= halves[STAGE_1200];
        end
    end
    assign rise_1200 = halves[STAGE_1200] && !r1200_d;

    mod_divider #(.MODULUS(BAUD_110_DIV)) u_110 (
        .clk(clk),
        .nrst(nrst),
        .en(rise_1200),
        .count(cnt_110),
        .tick(tick_110)
    ); // see R8

    // all selectable clock levels, indexed by switch code
    logic [7:0] source;
    logic top_level;
    assign source[BAUD_9600] = top_level; // see R6
    assign source[BAUD_150:BAUD_4800] = halves;
    assign source[BAUD_110] = cnt_110 == 4'(BAUD_110_DIV - 1);

    // top clock as a level: the count-zero state after the wrap, one base period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            top_level <= 1'b0;
        end else begin
            top_level <= top_tick || (top_level && !base_tick);
        end
    end

    // one switch per port feeds both bit clocks from a flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_clk <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                port_clk[p].tx <= source[sw_q[p]]; // see R9
                port_clk[p].rx <= source[sw_q[p]]; // see R9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [7:0] gap;
    logic seen_top;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap <= 8'h00;
            seen_top <= 1'b0;
        end else begin
            gap <= top_tick ? 8'h00 : gap + 8'h01;
            seen_top <= seen_top || top_tick;
        end
    end

    property p_port_a;
        (io_req && address[7:4] == nib_q && address[3:0] == PORT_A_LO)
            |=> io_sel.port_a && io_sel.parallel && !io_sel.port_b;
    endproperty
    a_port_a: assert property (p_port_a) else $error("no port A sel"); // see R1
    property p_csr;
        (io_req && address[7:4] == nib_q && address[3:0] == CSR_LO)
            |=> io_sel.csr && !io_sel.port_c;
    endproperty
    a_csr: assert property (p_csr) else $error("csr not selected"); // see R2

    property p_no_req;
        !io_req |=> !io_sel.parallel && !io_sel.serial;
    endproperty
    a_no_req: assert property (p_no_req) else $error("stray select"); // see R3

    sequence s_fast_gap;
        !cpu_clk_tick [*4] ##1 cpu_clk_tick;
    endsequence
    property p_cpu_fast;
        (fast_q && $stable(fast_q) && cpu_clk_tick) |=> s_fast_gap;
    endproperty
    a_cpu_fast: assert property (p_cpu_fast) else $error("cpu rate"); // see R4

    sequence s_base_gap;
        !base_tick [*8] ##1 !base_tick ##1 base_tick;
    endsequence
    property p_base;
        base_tick |=> s_base_gap;
    endproperty
    a_base: assert property (p_base) else $error("base rate wrong"); // see R5

    property p_top_gap;
        (top_tick && seen_top) |-> gap == 8'(BAUD_TOP_DIV * BASE_DIV - 1);
    endproperty
    a_top_gap: assert property (p_top_gap) else $error("top rate"); // see R6
    property p_halving;
        top_tick |=> halves == $past(halves) + 1'b1;
    endproperty
    a_halving: assert property (p_halving) else $error("no halving"); // see R7
    property p_div11;
        rise_1200 |=> cnt_110 == (($past(cnt_110) == 4'hA) ? 4'h0
            : $past(cnt_110) + 4'h1);
    endproperty
    a_div11: assert property (p_div11) else $error("110 div wrong"); // see R8
    property p_select;
        1'b1 |=> port_clk[0].tx == $past(source[sw_q[0]])
            && port_clk[0].rx == port_clk[0].tx;
    endproperty
    a_select: assert property (p_select) else $error("port clk sel"); // see R9
    property p_mirror;
        (io_cycle && mir_q) |=> address_out[15:8] == $past(address[7:0]);
    endproperty
    a_mirror: assert property (p_mirror) else $error("no mirror"); // see R10
    property p_free_run;
        1'b1 |-> ##[1:10] base_tick ##[1:140] top_tick;
    endproperty
    a_free_run: assert property (p_free_run) else $error("stopped"); // see R11

endmodule : io_decode_and_baud_clocks

// ### verif/serial_clk_sink.sv
/*
 * Far-side model of one serial controller's bit clock inputs.
 * Assumes the clock pair comes from logic on clk; it only measures.
 */
`timescale 1ns/1ps
module serial_clk_sink
    import io_clk_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // transmit and receive bit clock inputs
    input wire io_clk_pkg::serial_clk_s bit_clk,
    // measurements
    output logic [31:0] rises,
    output logic [31:0] period,
    output logic [31:0] high_len,
    output logic [31:0] splits
);
    logic prev_reg;
    logic [31:0] since_reg;
    logic [31:0] hcnt_reg;

    ////////////////////////////////////////////////////////////////////
    // period and high time of the transmit clock, one count per cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_reg <= 1'b0;
            since_reg <= 32'h0;
            hcnt_reg <= 32'h0;
            rises <= 32'h0;
            period <= 32'h0;
            high_len <= 32'h0;
        end else begin
            prev_reg <= bit_clk.tx;
            since_reg <= since_reg + 32'h1;
            hcnt_reg <= hcnt_reg + 32'h1;
            if (bit_clk.tx && !prev_reg) begin
                rises <= rises + 32'h1;
                period <= since_reg + 32'h1;
                since_reg <= 32'h0;
                hcnt_reg <= 32'h1;
            end
            if (!bit_clk.tx && prev_reg) begin
                high_len <= hcnt_reg;
            end
        end
    end

    // both inputs must see one clock, a split is counted
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            splits <= 32'h0;
        end else if (bit_clk.tx !== bit_clk.rx) begin
            splits <= splits + 32'h1;
        end
    end
endmodule : serial_clk_sink

// ### verif/io_decode_and_baud_clocks_tb_top.sv
/*
 * Self-checking bench for decode, mirroring and clock generation.
 * Assumes a 50 ns clock and straps changed inside tests, each change followed by settle cycles.
 */
`timescale 1ns/1ps
module io_decode_and_baud_clocks_tb_top;
    import io_clk_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] address = 16'h0000;
    logic io_cycle = 1'b0;
    logic strobe_n = 1'b1;
    logic [3:0] base_nibble = 4'h0;
    logic mirror_enable = 1'b0;
    logic cpu_fast = 1'b0;
    logic [1:0][2:0] baud_switch = '0;
    logic [15:0] address_out;
    io_sel_s io_sel;
    logic cpu_clk_tick;
    logic two_mhz_base_clock;
    serial_clk_s [1:0] port_clk;
    logic [31:0] rises [2];
    logic [31:0] period [2];
    logic [31:0] high_len [2];
    logic [31:0] splits [2];
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    io_decode_and_baud_clocks #(.NUM_PORTS(2)) i_io_decode_and_baud_clocks (
        .clk(clk), .nrst(nrst), .address(address), .io_cycle(io_cycle),
        .memory_request_strobe_n(strobe_n), .address_out(address_out),
        .io_sel(io_sel), .base_nibble(base_nibble),
        .mirror_enable(mirror_enable), .cpu_fast(cpu_fast),
        .baud_switch(baud_switch), .cpu_clk_tick(cpu_clk_tick),
        .two_mhz_base_clock(two_mhz_base_clock), .port_clk(port_clk)
    );
    // one far-side model per serial port
    for (genvar p = 0; p < 2; p++) begin : g_sink
        serial_clk_sink i_serial_clk_sink (
            .clk(clk), .nrst(nrst), .bit_clk(port_clk[p]),
            .rises(rises[p]), .period(period[p]),
            .high_len(high_len[p]), .splits(splits[p])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // 20 MHz clock, and a cycle ceiling well above the longest test
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            fails++;
            give_verdict();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task give_verdict();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    // present one processor cycle, return once the answer has landed
    task apply(input logic [15:0] a, input logic io, input logic sn);
        @(posedge clk);
        address <= a;
        io_cycle <= io;
        strobe_n <= sn;
        @(posedge clk);
        #1;
    endtask : apply

    ////////////////////////////////////////////////////////////////////
    // every low nibble, right and wrong block, each request kind
    task run_decode();
        io_sel_s e;
        logic [3:0] lo;
        base_nibble <= 4'h3;
        repeat (4) @(posedge clk);
        for (int h = 0; h < 2; h++) for (int l = 0; l < 16; l++) begin
            for (int k = 0; k < 3; k++) begin
                lo = l[3:0];
                e = '0;
                if (h == 0 && k == 0) begin
                    e.port_a = (lo == PORT_A_LO);
                    e.port_b = (lo == PORT_B_LO);
                    e.port_c = (lo == PORT_C_LO);
                    e.csr = (lo == CSR_LO);
                    e.parallel = (lo >= PORT_A_LO && lo <= CSR_LO);
                    e.serial = (lo == SERIAL_DATA_LO || lo == SERIAL_CTRL_LO);
                    e.serial_ctrl = (lo == SERIAL_CTRL_LO);
                end
                apply({8'h00, h ? 4'h5 : 4'h3, lo}, k != 1, k == 2);
                check(32'(io_sel), 32'(e));
            end
        end
    endtask : run_decode

    // mirror only while enabled and in an i/o cycle
    task run_mirror();
        @(posedge clk);
        mirror_enable <= 1'b1;
        repeat (4) @(posedge clk);
        apply(16'h1234, 1'b1, 1'b0);
        check(32'(address_out), 32'h3434);
        apply(16'h1234, 1'b0, 1'b0);
        check(32'(address_out), 32'h1234);
        @(posedge clk);
        mirror_enable <= 1'b0;
        repeat (4) @(posedge clk);
        apply(16'hABCD, 1'b1, 1'b0);
        check(32'(address_out), 32'hABCD);
    endtask : run_mirror

    // high time and period of the cpu tick or of the base clock
    task pulse_len(input int which, output int hi_n, output int per_n);
        logic s;
        logic p;
        p = 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            #1;
            s = which ? two_mhz_base_clock : cpu_clk_tick;
            if (s === 1'b1 && p === 1'b0) break;
            p = s;
        end
        p = 1'b1; // the sample that found the rise was high
        hi_n = 1;
        per_n = 0;
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            #1;
            s = which ? two_mhz_base_clock : cpu_clk_tick;
            per_n++;
            if (s === 1'b1 && p === 1'b0) break;
            if (s === 1'b1 && per_n == hi_n) hi_n++;
            p = s;
        end
    endtask : pulse_len

    task run_cpu_clk();
        int h;
        int n;
        for (int f = 0; f < 2; f++) begin
            @(posedge clk);
            cpu_fast <= f[0];
            repeat (6) @(posedge clk);
            pulse_len(0, h, n);
            check(32'(n), f ? CPU_FAST_DIV : CPU_SLOW_DIV);
        end
        pulse_len(1, h, n);
        check(32'(n), BASE_DIV);
        check(32'(h), BASE_DIV / 2);
    endtask : run_cpu_clk

    // every switch code on both ports, period seen at the far side
    task run_baud();
        int top;
        logic [31:0] r0;
        logic [31:0] r1;
        logic [31:0] e;
        top = BAUD_TOP_DIV * BASE_DIV;
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            baud_switch <= {c[2:0], c[2:0]};
            repeat (8) @(posedge clk);
            r0 = rises[0];
            r1 = rises[1];
            for (int i = 0; i < 30000; i++) begin
                @(posedge clk);
                #1;
                if (rises[0] >= r0 + 2 && rises[1] >= r1 + 2) break;
            end
            if (c == 0) e = top;
            else if (c == BAUD_110) e = BAUD_110_DIV * ((2 * top) << 2);
            else e = (2 * top) << (c - 1);
            check(period[0], e);
            check(period[1], e);
            if (c == 0) check(high_len[0], BASE_DIV);
        end
        check(splits[0] | splits[1], 32'h0);
    endtask : run_baud

    ////////////////////////////////////////////////////////////////////
    // reset, then each scenario in turn
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        run_decode();
        run_mirror();
        run_cpu_clk();
        run_baud();
        give_verdict();
    end
endmodule : io_decode_and_baud_clocks_tb_top
